// file: tmc_pin_control.sv
// Pin control of an 8-bit TV tuning controller: three general ports,
// serial merge, edge interrupts, reset/strap, overlay polarity, converters.
// Assumes synchronous pin inputs, one 50 MHz clock and pads outside that
// resolve each pin from dout/oe/pull_en.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "tmc_cfg.svh"

// ----------------------------------------------------------------------------
// One general port: data, direction and pull-up registers
// ----------------------------------------------------------------------------
module tmc_gpio_port #(
  parameter logic [7:0] LINE_MASK = 8'hff,
  parameter logic [7:0] OD_MASK   = 8'h00,
  parameter logic [7:0] PULL_OK   = 8'hff
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Register writes
  input  wire logic                 we_data,
  input  wire logic                 we_dir,
  input  wire logic                 we_pull,
  input  wire logic [7:0]           wdata,
  // Pins and alternate function
  input  wire logic [7:0]           pin_in,
  input  wire logic [7:0]           alt_and,
  output tmc_pkg::tmc_pin_type      pin,
  // Register views
  output logic [7:0]                data_q,
  output logic [7:0]                dir_q,
  output logic [7:0]                pull_q,
  output logic [7:0]                rd_val
);
  import tmc_pkg::*;

  logic [7:0] data_r;
  logic [7:0] dir_r;
  logic [7:0] pull_r;
  wire  [7:0] drive_lvl;

  // Absent lines never store a one; lines without pull-up never store one in the pull register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= `TMC_RST_BYTE;
      dir_r  <= `TMC_RST_BYTE;
      pull_r <= `TMC_RST_BYTE;
    end else begin
      if (we_data) data_r <= wdata & LINE_MASK;
      if (we_dir)  dir_r  <= wdata & LINE_MASK;
      if (we_pull) pull_r <= wdata & PULL_OK & LINE_MASK;
    end
  end

  // Output level, ANDed with the alternate signal where one is merged
  assign drive_lvl   = data_r & alt_and & LINE_MASK;
  // Push-pull lines drive both levels; open-drain lines only pull low
  assign pin.dout    = drive_lvl & ~OD_MASK;
  assign pin.oe      = dir_r & LINE_MASK & (~OD_MASK | ~drive_lvl);
  // Pull-up only on inputs that offer it
  assign pin.pull_en = ~dir_r & pull_r & PULL_OK & LINE_MASK;
  // Output lines read the data register, inputs read the pin
  assign rd_val      = ((dir_r & data_r) | (~dir_r & pin_in)) & LINE_MASK;
  assign data_q      = data_r;
  assign dir_q       = dir_r;
  assign pull_q      = pull_r;
endmodule : tmc_gpio_port

module tmc_pin_control #(
  parameter bit SYNC_POSITIVE  = 1'b0,
  parameter bit RGB_POSITIVE   = 1'b0,
  parameter bit BLANK_POSITIVE = 1'b0,
  parameter int PWM_NUM        = 6,
  parameter int VT_BITS        = 14
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  // Register port
  input  wire logic [4:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  output logic                         irq,
  // General ports
  input  wire logic [7:0]              port_a_lines_in,
  output tmc_pkg::tmc_pin_type         port_a_lines,
  input  wire logic [7:0]              port_b_lines_in,
  output tmc_pkg::tmc_pin_type         port_b_lines,
  input  wire logic [7:0]              port_c_lines_in,
  output tmc_pkg::tmc_pin_type         port_c_lines,
  // Serial peripheral signals
  input  wire tmc_pkg::tmc_serial_type serial_sig,
  // Reset, crystal and programming strap
  input  wire logic                    prog_level_high,
  output logic                         core_reset_n,
  output logic                         crystal_enable,
  output logic                         programming_mode,
  // Overlay
  input  wire logic                    hsync_in,
  input  wire logic                    vsync_in,
  output logic                         overlay_osc_run,
  input  wire tmc_pkg::tmc_osd_type    osd_active,
  output tmc_pkg::tmc_osd_type         osd_pins,
  // Converters and tuning
  output logic [PWM_NUM-1:0]           pwm_converter_outputs_out,
  output logic [PWM_NUM-1:0]           pwm_converter_outputs_oe,
  input  wire logic [3:0]              tuning_level_input,
  output logic                         voltage_tuning_output
);
  import tmc_pkg::*;

  // --------------------------------------------------------------------------
  // Timing figures in cycles
  // --------------------------------------------------------------------------
  localparam int PWM_STEP_CYC =
    `TMC_PWM_PERIOD_NS / (`TMC_CLK_PERIOD_NS * `TMC_PWM_STEPS);
  localparam logic [5:0] PWM_STEP_LAST = 6'(PWM_STEP_CYC - 1);

  // --------------------------------------------------------------------------
  // Reset release and programming strap
  // --------------------------------------------------------------------------
  logic              rst_meta_r;
  logic              rst_n_r;
  tmc_rst_state_type rst_state_r;
  tmc_rst_state_type rst_state_nxt;
  logic              prog_mode_r;
  wire               rst_n = rst_n_r;

  // Two-stage release; assertion acts at once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Program restarts and crystal runs only once reset is gone
  assign core_reset_n   = rst_n;
  assign crystal_enable = rst_n;

  // Strap caught in the second cycle after release (capture state), never by the reset itself
  always_comb begin
    case (rst_state_r)
      TMC_RST_HOLD:    rst_state_nxt = TMC_RST_CAPTURE;
      TMC_RST_CAPTURE: rst_state_nxt = TMC_RST_RUN;
      TMC_RST_RUN:     rst_state_nxt = TMC_RST_RUN;
      default:         rst_state_nxt = TMC_RST_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_state_r <= TMC_RST_HOLD;
      prog_mode_r <= 1'b0;
    end else begin
      rst_state_r <= rst_state_nxt;
      if (rst_state_r == TMC_RST_CAPTURE) prog_mode_r <= prog_level_high;
    end
  end
  assign programming_mode = prog_mode_r;

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  wire wr_a_data = reg_wr && (reg_addr == `TMC_ADDR_A_DATA);
  wire wr_a_dir  = reg_wr && (reg_addr == `TMC_ADDR_A_DIR);
  wire wr_a_pull = reg_wr && (reg_addr == `TMC_ADDR_A_PULL);
  wire wr_b_data = reg_wr && (reg_addr == `TMC_ADDR_B_DATA);
  wire wr_b_dir  = reg_wr && (reg_addr == `TMC_ADDR_B_DIR);
  wire wr_b_pull = reg_wr && (reg_addr == `TMC_ADDR_B_PULL);
  wire wr_c_data = reg_wr && (reg_addr == `TMC_ADDR_C_DATA);
  wire wr_c_dir  = reg_wr && (reg_addr == `TMC_ADDR_C_DIR);
  wire wr_c_pull = reg_wr && (reg_addr == `TMC_ADDR_C_PULL);
  wire wr_edge   = reg_wr && (reg_addr == `TMC_ADDR_EDGE);
  wire wr_stat   = reg_wr && (reg_addr == `TMC_ADDR_IRQ_STAT);
  wire wr_mask   = reg_wr && (reg_addr == `TMC_ADDR_IRQ_MASK);
  wire wr_vt_lo  = reg_wr && (reg_addr == `TMC_ADDR_VT_LO);
  wire wr_vt_hi  = reg_wr && (reg_addr == `TMC_ADDR_VT_HI);

  // --------------------------------------------------------------------------
  // General ports
  // --------------------------------------------------------------------------
  logic [7:0] a_data, a_dir, a_pull, a_rd;
  logic [7:0] b_data, b_dir, b_pull, b_rd;
  logic [7:0] c_data, c_dir, c_pull, c_rd;
  logic [7:0] c_alt;

  // Serial signals merged by AND on lines 0, 1 and 3; others pass data
  always_comb begin
    c_alt                 = 8'hff;
    c_alt[`TMC_C_BIT_SCL] = serial_sig.clk;
    c_alt[`TMC_C_BIT_SDA] = serial_sig.data;
    c_alt[`TMC_C_BIT_ENA] = serial_sig.enable;
  end

  // Port A: low nibble push-pull with pull-up, high nibble open-drain
  tmc_gpio_port #(
    .LINE_MASK (`TMC_A_LINES),
    .OD_MASK   (`TMC_A_OD),
    .PULL_OK   (`TMC_A_PULL_OK)
  ) u_port_a (
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .we_data (wr_a_data),
    .we_dir  (wr_a_dir),
    .we_pull (wr_a_pull),
    .wdata   (reg_wdata),
    .pin_in  (port_a_lines_in),
    .alt_and (8'hff),
    .pin     (port_a_lines),
    .data_q  (a_data),
    .dir_q   (a_dir),
    .pull_q  (a_pull),
    .rd_val  (a_rd)
  );

  // Port B: bits 3 and 7 do not exist and read zero
  tmc_gpio_port #(
    .LINE_MASK (`TMC_B_LINES),
    .OD_MASK   (`TMC_B_OD),
    .PULL_OK   (`TMC_B_PULL_OK)
  ) u_port_b (
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .we_data (wr_b_data),
    .we_dir  (wr_b_dir),
    .we_pull (wr_b_pull),
    .wdata   (reg_wdata),
    .pin_in  (port_b_lines_in),
    .alt_and (8'hff),
    .pin     (port_b_lines),
    .data_q  (b_data),
    .dir_q   (b_dir),
    .pull_q  (b_pull),
    .rd_val  (b_rd)
  );

  // Port C: all open-drain, serial merged before the drain driver
  tmc_gpio_port #(
    .LINE_MASK (`TMC_C_LINES),
    .OD_MASK   (`TMC_C_OD),
    .PULL_OK   (`TMC_C_PULL_OK)
  ) u_port_c (
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .we_data (wr_c_data),
    .we_dir  (wr_c_dir),
    .we_pull (wr_c_pull),
    .wdata   (reg_wdata),
    .pin_in  (port_c_lines_in),
    .alt_and (c_alt),
    .pin     (port_c_lines),
    .data_q  (c_data),
    .dir_q   (c_dir),
    .pull_q  (c_pull),
    .rd_val  (c_rd)
  );

  // --------------------------------------------------------------------------
  // Edge latches and interrupts
  // --------------------------------------------------------------------------
  logic [1:0]           edge_rise_r;
  logic                 pwr_prev_r;
  logic                 ir_prev_r;
  logic                 vsy_prev_r;
  logic [`TMC_IRQ_W-1:0] stat_r;
  logic [`TMC_IRQ_W-1:0] mask_r;
  logic [`TMC_IRQ_W-1:0] stat_set;

  // Sync inputs as active-high levels under the fixed polarity
  wire hs_act = SYNC_POSITIVE ? hsync_in : ~hsync_in;
  wire vsy_act = SYNC_POSITIVE ? vsync_in : ~vsync_in;

  wire pwr_pin = port_c_lines_in[`TMC_C_BIT_PWR];
  wire ir_pin  = port_c_lines_in[`TMC_C_BIT_IR];
  // Edge select for the power and IR latches: one picks rising, zero falling
  wire pwr_edge = edge_rise_r[0] ? (pwr_pin & ~pwr_prev_r) : (~pwr_pin & pwr_prev_r);
  wire ir_edge  = edge_rise_r[1] ? (ir_pin & ~ir_prev_r) : (~ir_pin & ir_prev_r);

  always_comb begin
    stat_set                 = '0;
    stat_set[`TMC_IRQ_PWR]   = pwr_edge;
    stat_set[`TMC_IRQ_IR]    = ir_edge;
    stat_set[`TMC_IRQ_VSYNC] = vsy_act & ~vsy_prev_r;
  end

  // Write-one-to-clear; a new event in the same cycle keeps its bit set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_rise_r <= 2'h0;
      pwr_prev_r  <= 1'b0;
      ir_prev_r   <= 1'b0;
      vsy_prev_r  <= 1'b0;
      stat_r      <= '0;
      mask_r      <= '0;
    end else begin
      pwr_prev_r <= pwr_pin;
      ir_prev_r  <= ir_pin;
      vsy_prev_r <= vsy_act;
      if (wr_edge) edge_rise_r <= reg_wdata[1:0];
      if (wr_mask) mask_r <= reg_wdata[`TMC_IRQ_W-1:0];
      stat_r <= (stat_r & ~(wr_stat ? reg_wdata[`TMC_IRQ_W-1:0] : '0)) | stat_set;
    end
  end
  assign irq = |(stat_r & mask_r);

  // --------------------------------------------------------------------------
  // Overlay oscillator gate and colour outputs
  // --------------------------------------------------------------------------
  // Either sync in its active state halts the overlay dot oscillator
  assign overlay_osc_run = ~(hs_act | vsy_act);

  // Registered push-pull levels with mask-fixed polarity
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osd_pins <= {~RGB_POSITIVE, ~RGB_POSITIVE, ~RGB_POSITIVE, ~BLANK_POSITIVE};
    end else begin
      osd_pins.red   <= osd_active.red   ~^ RGB_POSITIVE;
      osd_pins.green <= osd_active.green ~^ RGB_POSITIVE;
      osd_pins.blue  <= osd_active.blue  ~^ RGB_POSITIVE;
      osd_pins.blank <= osd_active.blank ~^ BLANK_POSITIVE;
    end
  end

  // --------------------------------------------------------------------------
  // Pulse-width converters
  // --------------------------------------------------------------------------
  logic [5:0] step_cnt_r;
  logic [5:0] phase_r;
  logic [5:0] duty_r [PWM_NUM];
  wire        step_en = (step_cnt_r == PWM_STEP_LAST);

  // Divider gives one step enable per 1/64 of the converter period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_r <= 6'h00;
      phase_r    <= 6'h00;
    end else begin
      step_cnt_r <= step_en ? 6'h00 : step_cnt_r + 6'h01;
      if (step_en) phase_r <= phase_r + 6'h01;
    end
  end

  // Released (high) while phase is below duty, pulled low otherwise
  generate
    for (genvar i = 0; i < PWM_NUM; i++) begin : g_pwm
      wire wr_duty = reg_wr && (reg_addr == 5'(`TMC_ADDR_PWM0 + i));
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          duty_r[i]                   <= 6'h00;
          pwm_converter_outputs_oe[i] <= 1'b1;
        end else begin
          if (wr_duty) duty_r[i] <= reg_wdata[5:0];
          pwm_converter_outputs_oe[i] <= ~(phase_r < duty_r[i]);
        end
      end
    end
  endgenerate
  assign pwm_converter_outputs_out = '0;

  // --------------------------------------------------------------------------
  // Tuning comparator and voltage synthesis cell
  // --------------------------------------------------------------------------
  logic [3:0]         tune_lvl_r;
  logic [VT_BITS-1:0] vt_val_r;
  logic [VT_BITS-1:0] vt_cnt_r;
  logic               vt_out_r;

  // Comparator code clamped to its ten levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_lvl_r <= 4'h0;
    end else begin
      tune_lvl_r <= (tuning_level_input > `TMC_TUNE_MAX) ? `TMC_TUNE_MAX
                                                         : tuning_level_input;
    end
  end

  // 14-bit cell: free counter compared with the tuning word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vt_val_r <= '0;
      vt_cnt_r <= '0;
      vt_out_r <= 1'b0;
    end else begin
      if (wr_vt_lo) vt_val_r[7:0] <= reg_wdata;
      if (wr_vt_hi) vt_val_r[VT_BITS-1:8] <= reg_wdata[VT_BITS-9:0];
      vt_cnt_r <= vt_cnt_r + 1'b1;
      vt_out_r <= (vt_cnt_r < vt_val_r);
    end
  end
  assign voltage_tuning_output = vt_out_r;

  // --------------------------------------------------------------------------
  // Read data, one cycle after the strobe; unmapped reads zero
  // --------------------------------------------------------------------------
  logic [7:0] rd_pwm;
  always_comb begin
    rd_pwm = 8'h00;
    for (int k = 0; k < PWM_NUM; k++) begin
      if (reg_addr == 5'(`TMC_ADDR_PWM0 + k)) rd_pwm = {2'h0, duty_r[k]};
    end
  end

  wire [7:0] rd_mux =
    (reg_addr == `TMC_ADDR_A_DATA)   ? a_rd :
    (reg_addr == `TMC_ADDR_A_DIR)    ? a_dir :
    (reg_addr == `TMC_ADDR_A_PULL)   ? a_pull :
    (reg_addr == `TMC_ADDR_B_DATA)   ? b_rd :
    (reg_addr == `TMC_ADDR_B_DIR)    ? b_dir :
    (reg_addr == `TMC_ADDR_B_PULL)   ? b_pull :
    (reg_addr == `TMC_ADDR_C_DATA)   ? c_rd :
    (reg_addr == `TMC_ADDR_C_DIR)    ? c_dir :
    (reg_addr == `TMC_ADDR_C_PULL)   ? c_pull :
    (reg_addr == `TMC_ADDR_EDGE)     ? {6'h00, edge_rise_r} :
    (reg_addr == `TMC_ADDR_IRQ_STAT) ? {5'h00, stat_r} :
    (reg_addr == `TMC_ADDR_IRQ_MASK) ? {5'h00, mask_r} :
    (reg_addr == `TMC_ADDR_TUNE_LVL) ? {4'h0, tune_lvl_r} :
    (reg_addr == `TMC_ADDR_VT_LO)    ? vt_val_r[7:0] :
    (reg_addr == `TMC_ADDR_VT_HI)    ? {2'h0, vt_val_r[VT_BITS-1:8]} :
    (reg_addr == `TMC_ADDR_STATUS)   ? {5'h00, hs_act, vsy_act, prog_mode_r} :
    rd_pwm;

  // Data held only for the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else        reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end
endmodule : tmc_pin_control

// file: tmc_cfg.svh
// Constants of the tuning-controller pin block: register offsets, line masks,
// reset values and timing figures.
// Assumes inclusion by bare name from the package and the pin block.
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (5-bit address, 8-bit data)
// ----------------------------------------------------------------------------
`define TMC_ADDR_A_DATA   5'h00
`define TMC_ADDR_A_DIR    5'h01
`define TMC_ADDR_A_PULL   5'h02
`define TMC_ADDR_B_DATA   5'h03
`define TMC_ADDR_B_DIR    5'h04
`define TMC_ADDR_B_PULL   5'h05
`define TMC_ADDR_C_DATA   5'h06
`define TMC_ADDR_C_DIR    5'h07
`define TMC_ADDR_C_PULL   5'h08
`define TMC_ADDR_EDGE     5'h09
`define TMC_ADDR_IRQ_STAT 5'h0a
`define TMC_ADDR_IRQ_MASK 5'h0b
`define TMC_ADDR_TUNE_LVL 5'h0c
`define TMC_ADDR_VT_LO    5'h0d
`define TMC_ADDR_VT_HI    5'h0e
`define TMC_ADDR_STATUS   5'h0f
`define TMC_ADDR_PWM0     5'h10

// ----------------------------------------------------------------------------
// Line masks
// ----------------------------------------------------------------------------
`define TMC_A_LINES   8'hff
`define TMC_A_OD      8'hf0
`define TMC_A_PULL_OK 8'h0f
`define TMC_B_LINES   8'h77
`define TMC_B_OD      8'h00
`define TMC_B_PULL_OK 8'h77
`define TMC_C_LINES   8'hff
`define TMC_C_OD      8'hff
`define TMC_C_PULL_OK 8'h0f
`define TMC_C_BIT_SCL  0
`define TMC_C_BIT_SDA  1
`define TMC_C_BIT_ENA  3
`define TMC_C_BIT_PWR  4
`define TMC_C_BIT_IR   6

// ----------------------------------------------------------------------------
// Interrupt status / edge bits and reset values
// ----------------------------------------------------------------------------
`define TMC_IRQ_PWR   0
`define TMC_IRQ_IR    1
`define TMC_IRQ_VSYNC 2
`define TMC_IRQ_W     3
`define TMC_RST_BYTE  8'h00
`define TMC_TUNE_MAX  4'h9

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TMC_CLK_PERIOD_NS 20
`define TMC_PWM_PERIOD_NS 32000
`define TMC_PWM_STEPS     64

`endif

// file: tmc_pkg.sv
// Types shared by the tuning-controller pin block.
// Assumes tmc_cfg.svh sits in the same folder.
package tmc_pkg;
  `include "tmc_cfg.svh"

  // Three-signal view of up to eight pins of one port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } tmc_pin_type;

  // Serial peripheral signals merged onto port C
  typedef struct packed {
    logic clk;
    logic data;
    logic enable;
  } tmc_serial_type;

  // Overlay colour and blanking levels
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
    logic blank;
  } tmc_osd_type;

  // Reset sequencing, Gray along hold -> capture -> run
  typedef enum logic [1:0] {
    TMC_RST_HOLD    = 2'b00,
    TMC_RST_CAPTURE = 2'b01,
    TMC_RST_RUN     = 2'b11
  } tmc_rst_state_type;
endpackage : tmc_pkg

// file: tmc_board_model.sv
// Board model: resolves the pins of one general port.
// Assumes the pad view of tmc_pin_type; one instance per port.
`timescale 1ns/1ns
// ----
// Pin resolution
// ----
module tmc_board_model (
  // Device side
  input  wire tmc_pkg::tmc_pin_type pin,
  // Board side
  input  wire logic [7:0]           ext,
  output logic [7:0]                level
);
  import tmc_pkg::*;
  // Driven lines win, else the pull-up, else the board's own level;
  // an undriven unpulled line never keeps the device's last value
  assign level = (pin.oe & pin.dout) | (~pin.oe & (pin.pull_en | ext));
endmodule : tmc_board_model

// file: tmc_pin_control_props.sv
// Port checker of the tuning-controller pin block.
// Assumes default (negative) sync and colour polarity.
`timescale 1ns/1ns
// ----
// Properties
// ----
module tmc_pin_control_props (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  // Observed ports
  input wire logic                    reg_wr,
  input wire tmc_pkg::tmc_pin_type    port_a_lines,
  input wire tmc_pkg::tmc_pin_type    port_b_lines,
  input wire tmc_pkg::tmc_pin_type    port_c_lines,
  input wire tmc_pkg::tmc_serial_type serial_sig,
  input wire logic                    core_reset_n,
  input wire logic                    crystal_enable,
  input wire logic                    hsync_in,
  input wire logic                    vsync_in,
  input wire logic                    overlay_osc_run,
  input wire tmc_pkg::tmc_osd_type    osd_active,
  input wire tmc_pkg::tmc_osd_type    osd_pins
);
  import tmc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_a_od; port_a_lines.dout[7:4] == 4'h0 && port_a_lines.pull_en[7:4] == 4'h0; endproperty
  a_a_od: assert property (p_a_od) else $error("port a upper lines drive or pull");
  property p_c_od; port_c_lines.dout == 8'h00 && port_c_lines.pull_en[7:4] == 4'h0; endproperty
  a_c_od: assert property (p_c_od) else $error("port c not open drain");
  property p_b_gap; ((port_b_lines.oe | port_b_lines.pull_en) & 8'h88) == 8'h00; endproperty
  a_b_gap: assert property (p_b_gap) else $error("port b absent line active");
  // A low serial clock keeps a driven line low while the registers stand
  property p_clk_merge;
    !serial_sig.clk && !$past(reg_wr) && $past(port_c_lines.oe[0]) |-> port_c_lines.oe[0];
  endproperty
  a_clk_merge: assert property (p_clk_merge) else $error("serial clock merge lost");
  property p_rst_seq; $rose(arst_n) |-> !core_reset_n ##1 !core_reset_n ##1 core_reset_n; endproperty
  a_rst_seq: assert property (p_rst_seq) else $error("restart timing off");
  // Watched through the reset itself, so the default disable is lifted
  property p_xtal; disable iff (1'b0) !arst_n |=> !crystal_enable; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal runs in reset");
  property p_osc; overlay_osc_run == (hsync_in && vsync_in); endproperty
  a_osc: assert property (p_osc) else $error("overlay oscillator vs sync");
  property p_osd; osd_pins == ~$past(osd_active); endproperty
  a_osd: assert property (p_osd) else $error("overlay pin polarity");
endmodule : tmc_pin_control_props

bind tmc_pin_control tmc_pin_control_props tmc_pin_control_props_i (
  .sys_clk, .arst_n, .reg_wr, .port_a_lines, .port_b_lines, .port_c_lines,
  .serial_sig, .core_reset_n, .crystal_enable, .hsync_in, .vsync_in,
  .overlay_osc_run, .osd_active, .osd_pins
);

// file: tb_top.sv
// Bench of the tuning-controller pin block: register tasks and scenarios.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/1ns
// ----
// Bench
// ----
module tb_top;
  import tmc_pkg::*;
  logic           sys_clk, arst_n, reg_wr, reg_rd, irq, hsync_in, vsync_in;
  logic           prog_level_high, programming_mode, core_reset_n, crystal_enable;
  logic [4:0]     reg_addr;
  logic [7:0]     reg_wdata, reg_rdata, ext_a, ext_b, ext_c;
  logic [7:0]     port_a_lines_in, port_b_lines_in, port_c_lines_in;
  logic [3:0]     tuning_level_input;
  logic [5:0]     pwm_converter_outputs_oe;
  logic           voltage_tuning_output;
  tmc_pin_type    port_a_lines, port_b_lines, port_c_lines;
  tmc_serial_type serial_sig;
  tmc_osd_type    osd_active;
  int             err_total, cmp_count, n;

  tmc_pin_control tmc_pin_control_i (
    .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .port_a_lines_in, .port_a_lines, .port_b_lines_in, .port_b_lines,
    .port_c_lines_in, .port_c_lines, .serial_sig, .prog_level_high, .core_reset_n,
    .crystal_enable, .programming_mode, .hsync_in, .vsync_in, .overlay_osc_run(),
    .osd_active, .osd_pins(), .pwm_converter_outputs_out(), .pwm_converter_outputs_oe,
    .tuning_level_input, .voltage_tuning_output
  );
  tmc_board_model brd_a_i (.pin(port_a_lines), .ext(ext_a), .level(port_a_lines_in));
  tmc_board_model brd_b_i (.pin(port_b_lines), .ext(ext_b), .level(port_b_lines_in));
  tmc_board_model brd_c_i (.pin(port_c_lines), .ext(ext_c), .level(port_c_lines_in));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Strobes drop for a cycle between calls, so no signal is set twice in a step
  task automatic wr(logic [4:0] a, logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(string what, logic [4:0] a, logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    chk(what, reg_rdata, exp);
    @(posedge sys_clk);
  endtask : rd

  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Watchdog: the scenarios need about 370 us
  initial begin
    #1000000;
    err_total++;
    end_of_test();
  end

  initial begin
    {sys_clk, arst_n, reg_wr, reg_rd, prog_level_high} = '0;
    {reg_addr, reg_wdata, ext_a, ext_b, ext_c, osd_active, tuning_level_input} = '0;
    {hsync_in, vsync_in, serial_sig} = '1;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (n = 0; n < 16; n++) rd("reset value", n[4:0], 8'h00);
    wr(5'h1f, 8'hff);
    rd("unmapped", 5'h1f, 8'h00);
    // Port A: output then pulled input
    wr(5'h01, 8'hff);
    wr(5'h00, 8'ha5);
    chk("a oe", port_a_lines.oe, 8'h5f);
    chk("a dout", port_a_lines.dout, 8'h05);
    rd("a out read", 5'h00, 8'ha5);
    wr(5'h01, 8'h00);
    wr(5'h02, 8'hff);
    ext_a <= 8'h30;
    chk("a pull", port_a_lines.pull_en, 8'h0f);
    rd("a in read", 5'h00, 8'h3f);
    // Port B: absent lines stay dead both ways
    wr(5'h04, 8'hff);
    wr(5'h03, 8'hff);
    chk("b oe", port_b_lines.oe, 8'h77);
    wr(5'h04, 8'h00);
    wr(5'h05, 8'hff);
    ext_b <= 8'h88;
    rd("b in read", 5'h03, 8'h77);
    // Port C: serial merge on lines 0, 1 and 3
    wr(5'h07, 8'hff);
    wr(5'h06, 8'hff);
    chk("c idle", port_c_lines.oe, 8'h00);
    // Each serial level held low two cycles so the merge is seen standing
    for (n = 0; n < 3; n++) begin
      serial_sig <= ~(3'b100 >> n);
      repeat (2) @(posedge sys_clk);
      chk("c merge", port_c_lines.oe, 8'h01 << ((n == 2) ? 3 : n));
    end
    serial_sig <= '1;
    wr(5'h06, 8'h0f);
    chk("c low", port_c_lines.oe, 8'hf0);
    wr(5'h07, 8'h00);
    wr(5'h08, 8'hff);
    chk("c pull", port_c_lines.pull_en, 8'h0f);
    // Edge latches: line 4 rising, line 6 falling; wrong edge on line 6 first
    wr(5'h09, 8'h01);
    wr(5'h0b, 8'h07);
    ext_c <= 8'h40;
    repeat (3) @(posedge sys_clk);
    rd("wrong edge", 5'h0a, 8'h00);
    ext_c <= 8'h10;
    repeat (3) @(posedge sys_clk);
    rd("edge status", 5'h0a, 8'h03);
    vsync_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd("vsync status", 5'h0a, 8'h07);
    rd("sync status", 5'h0f, 8'h02);
    chk("irq on", {7'h00, irq}, 8'h01);
    wr(5'h0b, 8'h00);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(5'h0a, 8'h07);
    rd("cleared", 5'h0a, 8'h00);
    // Tuning comparator clamps at its tenth level
    tuning_level_input <= 4'hc;
    osd_active <= 4'h5;
    repeat (2) @(posedge sys_clk);
    rd("tune clamp", 5'h0c, 8'h09);
    // Converter 0 at duty 1 releases 25 of 1600 cycles
    wr(5'h10, 8'h01);
    n = 0;
    repeat (1600) begin
      @(negedge sys_clk);
      if (pwm_converter_outputs_oe[0] === 1'b0) n++;
    end
    chk("pwm release", n[7:0], 8'h19);
    // Tuning cell word 0x105 is high 261 of 16384 cycles
    wr(5'h0d, 8'h05);
    wr(5'h0e, 8'h01);
    n = 0;
    repeat (16384) begin
      @(negedge sys_clk);
      if (voltage_tuning_output === 1'b1) n++;
    end
    chk("tune hi", n[15:8], 8'h01);
    chk("tune lo", n[7:0], 8'h05);
    // Restart with the programming level on the test pin
    osd_active <= '0;
    prog_level_high <= 1'b1;
    arst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("xtal off", {7'h00, crystal_enable}, 8'h00);
    arst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("prog mode", {7'h00, programming_mode}, 8'h01);
    rd("restart", 5'h01, 8'h00);
    end_of_test();
  end
endmodule : tb_top
